//--- nvac_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module nvac_cpu_model (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire logic irqReq, // vector request
	input wire logic [3:0] ackDelay, // cycles before service, 0 never
	output logic timerTick, // slow write timer
	output logic irqAck // service pulse
);
	logic [3:0] waitCnt_q;
	// period is no multiple of mclk, so tick edges drift against the clock
	initial begin
		timerTick = 1'b0;
		forever #67 timerTick = ~timerTick;
	end
	// the model never idles or sleeps, so no cycle in flight is cut short
	// vector taken after the chosen delay; any delay of 1 or more avoids a double service
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt_q <= 4'h0;
			irqAck <= 1'b0;
		end else begin
			irqAck <= 1'b0;
			if (!irqReq || ackDelay == 4'h0) waitCnt_q <= 4'h0;
			else if (waitCnt_q == ackDelay) begin
				irqAck <= 1'b1;
				waitCnt_q <= 4'h0;
			end else waitCnt_q <= waitCnt_q + 4'h1;
		end
	end
endmodule : nvac_cpu_model
`default_nettype wire

//--- nvac_eeprom_checker.sv
`timescale 1ns/1ns
`default_nettype none
module nvac_eeprom_checker (
	input wire logic mclk, // clock
	input wire logic rst_n, // reset
	input wire nvac_pkg::nvac_sfr_req_t sfrReq, // cpu access
	input wire logic [7:0] sfrRdata, // read data
	input wire logic timerTick, // slow timer
	input wire logic nvIrqEnable, // irq enable
	input wire logic globalIrqEnable, // global enable
	input wire logic stackFull, // stack full
	input wire logic irqAck, // service pulse
	input wire logic nvIrqFlag, // irq flag
	input wire logic irqReq, // vector request
	input wire logic busy // cycle running
);
	logic [7:0] ptr_q;
	logic [7:0] bank_q;
	logic [1:0] en_q;
	logic hit;
	logic go;
	logic [7:0] w;
	// control is only seen through the indirect port, so shadow pointer and bank
	assign hit = sfrReq.addr == 8'h02 && ptr_q == 8'h40 && bank_q == 8'h01;
	assign go = sfrReq.wr && hit && !busy;
	assign w = sfrReq.wdata;
	// shadow of both enables; a strobe only counts if its enable was already set
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ptr_q <= 8'h00;
			bank_q <= 8'h00;
			en_q <= 2'h0;
		end else if (sfrReq.wr) begin
			if (sfrReq.addr == 8'h03) ptr_q <= w;
			if (sfrReq.addr == 8'h04) bank_q <= w;
			if (hit) en_q <= {w[3], w[1]};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_PROG_GO: assert property (go && w[2] && en_q[1] |-> ##[1:2] busy)
		else $error("program strobe did not start a cycle");
	AST_PROG_BLOCK: assert property (go && w[2] && !w[0] && !en_q[1] |=> !busy[*2])
		else $error("program cycle started without enable");
	AST_FETCH_BLOCK: assert property (go && w[0] && !w[2] && !en_q[0] |=> !busy[*2])
		else $error("read cycle started without enable");
	AST_FETCH_END: assert property (go && w[0] && !w[2] && en_q[0] |-> ##[1:2] busy ##[1:6] !busy)
		else $error("read cycle did not run and end");
	AST_FLAG_CAUSE: assert property ($rose(nvIrqFlag) |-> $fell(busy))
		else $error("flag rose without a cycle ending");
	// a service in the same cycle drops the request, so it is left out of the trigger
	AST_IRQ_REQ: assert property (nvIrqFlag && !irqAck && nvIrqEnable && globalIrqEnable && !stackFull |=> irqReq)
		else $error("vector request missing");
	// the request follows the flag's new value, gated by last cycle's enables
	AST_IRQ_GATE: assert property (irqReq |-> nvIrqFlag && $past(nvIrqEnable && globalIrqEnable && !stackFull))
		else $error("vector request without cause");
	AST_ACK_CLEAR: assert property (irqAck && !busy |=> !nvIrqFlag)
		else $error("flag kept after service");
	AST_UPPER_ZERO: assert property (sfrReq.rd && hit |=> sfrRdata[7:4] == 4'h0)
		else $error("control upper bits not zero");
	COV_PROG: cover property (go && w[2] && en_q[1]);
	COV_ACK: cover property (irqAck && nvIrqFlag);
	COV_END: cover property ($fell(busy));
endmodule : nvac_eeprom_checker
bind nvac_eeprom_ctrl nvac_eeprom_checker chk (.mclk(mclk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
	.timerTick(timerTick), .nvIrqEnable(nvIrqEnable), .globalIrqEnable(globalIrqEnable), .stackFull(stackFull),
	.irqAck(irqAck), .nvIrqFlag(nvIrqFlag), .irqReq(irqReq), .busy(busy));
`default_nettype wire

//--- nvac_eeprom_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module nvac_eeprom_ctrl #(
	parameter int DEPTH = nvac_pkg::NVAC_DEPTH,
	parameter int READ_CYCLES = nvac_pkg::NVAC_READ_CYCLES,
	parameter int WRITE_TICKS = nvac_pkg::NVAC_WRITE_TICKS
) (
	input wire logic mclk, // system clock, 100 MHz
	input wire logic rst_n, // power-on reset, async, active low
	input wire nvac_pkg::nvac_sfr_req_t sfrReq, // cpu register access
	output logic [7:0] sfrRdata, // read data, one cycle after request
	input wire logic timerTick, // slow programming timer clock, async
	input wire logic nvIrqEnable, // eeprom interrupt enable
	input wire logic globalIrqEnable, // global interrupt enable
	input wire logic stackFull, // cpu stack has no free entry
	input wire logic irqAck, // cpu is servicing the eeprom interrupt
	output logic nvIrqFlag, // eeprom interrupt request flag
	output logic irqReq, // vector request to the cpu
	output logic busy // read or programming cycle in progress
);
	localparam int AW = $clog2(DEPTH);
	localparam int HW = AW - 8;
	localparam int RCW = $clog2(READ_CYCLES + 1);

	// register state
	logic [7:0] addrLow_q;
	logic [HW-1:0] addrHigh_q;
	logic [7:0] dataByte_q;
	logic [7:0] pointer_q;
	logic [7:0] bankSelect_q;
	logic programEnable_q;
	logic programStrobe_q;
	logic fetchEnable_q;
	logic fetchStrobe_q;
	logic irqFlag_q;
	logic irqReq_q;
	logic busy_q;
	logic [7:0] rdata_q;

	// cycle state
	nvac_pkg::nvac_state_t state_q;
	logic [RCW-1:0] readCount_q;
	logic [AW-1:0] cycleAddr_q;
	logic [7:0] cycleData_q;
	logic [7:0] mem [DEPTH];

	// decode wires
	logic indirect;
	logic [7:0] effBank;
	logic [7:0] effOfs;
	logic hitAddrLow;
	logic hitAddrHigh;
	logic hitDataByte;
	logic hitControl;
	logic hitPointer;
	logic hitBank;
	logic writeCtrl;
	logic startProgram;
	logic startFetch;
	logic readDone;
	logic writeDone;
	logic [7:0] controlRead;
	logic [7:0] readMux;

	// the indirect port substitutes the pointer for the offset
	always_comb begin
		indirect = (sfrReq.addr == nvac_pkg::NVAC_INDIRECT_PORT_OFS);
		effBank = bankSelect_q;
		effOfs = indirect ? pointer_q : sfrReq.addr;
	end

	// address decode; control only through the indirect port in bank 1
	always_comb begin
		hitAddrLow = 1'b0;
		hitAddrHigh = 1'b0;
		hitDataByte = 1'b0;
		hitControl = 1'b0;
		hitPointer = 1'b0;
		hitBank = 1'b0;
		if (!indirect && sfrReq.addr == nvac_pkg::NVAC_POINTER_OFS) begin
			hitPointer = 1'b1;
		end else if (!indirect && sfrReq.addr == nvac_pkg::NVAC_BANK_SELECT_OFS) begin
			hitBank = 1'b1;
		end else if (indirect && effBank == nvac_pkg::NVAC_CONTROL_BANK
				&& effOfs == nvac_pkg::NVAC_CONTROL_OFS) begin
			hitControl = 1'b1;
		end else if (effBank == nvac_pkg::NVAC_DATA_BANK) begin
			if (effOfs == nvac_pkg::NVAC_ADDR_LOW_OFS) begin
				hitAddrLow = 1'b1;
			end else if (effOfs == nvac_pkg::NVAC_ADDR_HIGH_OFS) begin
				hitAddrHigh = 1'b1;
			end else if (effOfs == nvac_pkg::NVAC_DATA_BYTE_OFS) begin
				hitDataByte = 1'b1;
			end
		end
	end

	// strobe sets need the enable already stored and an idle engine;
	// an enable written in the same instruction does not count
	always_comb begin
		writeCtrl = sfrReq.wr && hitControl;
		startProgram = writeCtrl && sfrReq.wdata[nvac_pkg::NVAC_PROG_BIT]
			&& programEnable_q && !busy_q;
		// if both strobes arrive together, programming takes precedence
		startFetch = writeCtrl && sfrReq.wdata[nvac_pkg::NVAC_FETCH_BIT]
			&& fetchEnable_q && !busy_q && !startProgram;
	end

	// control register readback; unimplemented bits are zero
	always_comb begin
		controlRead = 8'h00;
		controlRead[nvac_pkg::NVAC_FETCH_BIT] = fetchStrobe_q;
		controlRead[nvac_pkg::NVAC_FETCH_EN_BIT] = fetchEnable_q;
		controlRead[nvac_pkg::NVAC_PROG_BIT] = programStrobe_q;
		controlRead[nvac_pkg::NVAC_PROG_EN_BIT] = programEnable_q;
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		readMux = 8'h00;
		if (hitAddrLow) begin
			readMux = addrLow_q;
		end else if (hitAddrHigh) begin
			readMux = 8'(addrHigh_q);
		end else if (hitDataByte) begin
			readMux = dataByte_q;
		end else if (hitControl) begin
			readMux = controlRead;
		end else if (hitPointer) begin
			readMux = pointer_q;
		end else if (hitBank) begin
			readMux = bankSelect_q;
		end
	end

	// registered read data
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= nvac_pkg::NVAC_BYTE_RESET;
		end else if (sfrReq.rd) begin
			rdata_q <= readMux;
		end
	end

	// pointer and bank select; bank 0 after power-on keeps control hidden
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_q <= nvac_pkg::NVAC_BYTE_RESET;
			bankSelect_q <= nvac_pkg::NVAC_BYTE_RESET;
		end else begin
			if (sfrReq.wr && hitPointer) begin
				pointer_q <= sfrReq.wdata;
			end
			if (sfrReq.wr && hitBank) begin
				bankSelect_q <= sfrReq.wdata;
			end
		end
	end

	// address registers; high register keeps only the implemented bits
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			addrLow_q <= nvac_pkg::NVAC_BYTE_RESET;
			addrHigh_q <= '0;
		end else begin
			if (sfrReq.wr && hitAddrLow) begin
				addrLow_q <= sfrReq.wdata;
			end
			if (sfrReq.wr && hitAddrHigh) begin
				addrHigh_q <= sfrReq.wdata[HW-1:0];
			end
		end
	end

	// data byte: a finished read overrides a software write in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			dataByte_q <= nvac_pkg::NVAC_BYTE_RESET;
		end else if (readDone) begin
			dataByte_q <= mem[cycleAddr_q];
		end else if (sfrReq.wr && hitDataByte) begin
			dataByte_q <= sfrReq.wdata;
		end
	end

	// enable bits are plain storage; power-on leaves all of them clear
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			programEnable_q <= nvac_pkg::NVAC_CONTROL_RESET[nvac_pkg::NVAC_PROG_EN_BIT];
			fetchEnable_q <= nvac_pkg::NVAC_CONTROL_RESET[nvac_pkg::NVAC_FETCH_EN_BIT];
		end else if (writeCtrl) begin
			programEnable_q <= sfrReq.wdata[nvac_pkg::NVAC_PROG_EN_BIT];
			fetchEnable_q <= sfrReq.wdata[nvac_pkg::NVAC_FETCH_EN_BIT];
		end
	end

	// strobes: set only by an accepted start, cleared only by hardware;
	// software writing zero cannot abort a cycle already under way
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			programStrobe_q <= nvac_pkg::NVAC_CONTROL_RESET[nvac_pkg::NVAC_PROG_BIT];
			fetchStrobe_q <= nvac_pkg::NVAC_CONTROL_RESET[nvac_pkg::NVAC_FETCH_BIT];
		end else begin
			if (startProgram) begin
				programStrobe_q <= 1'b1;
			end else if (writeDone) begin
				programStrobe_q <= 1'b0;
			end
			if (startFetch) begin
				fetchStrobe_q <= 1'b1;
			end else if (readDone) begin
				fetchStrobe_q <= 1'b0;
			end
		end
	end

	// cycle engine; address and data are captured at the start so later
	// register writes cannot disturb a cycle in flight
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= nvac_pkg::NVAC_IDLE;
			readCount_q <= '0;
			cycleAddr_q <= '0;
			cycleData_q <= nvac_pkg::NVAC_BYTE_RESET;
			busy_q <= 1'b0;
		end else begin
			case (state_q)
				nvac_pkg::NVAC_IDLE: begin
					if (startProgram) begin
						state_q <= nvac_pkg::NVAC_WRITING;
						cycleAddr_q <= {addrHigh_q, addrLow_q};
						cycleData_q <= dataByte_q;
						busy_q <= 1'b1;
					end else if (startFetch) begin
						state_q <= nvac_pkg::NVAC_READING;
						cycleAddr_q <= {addrHigh_q, addrLow_q};
						readCount_q <= '0;
						busy_q <= 1'b1;
					end
				end
				nvac_pkg::NVAC_READING: begin
					if (readDone) begin
						state_q <= nvac_pkg::NVAC_IDLE;
						busy_q <= 1'b0;
					end else begin
						readCount_q <= readCount_q + 1'b1;
					end
				end
				nvac_pkg::NVAC_WRITING: begin
					if (writeDone) begin
						state_q <= nvac_pkg::NVAC_IDLE;
						busy_q <= 1'b0;
					end
				end
				default: begin
					state_q <= nvac_pkg::NVAC_IDLE;
					busy_q <= 1'b0;
				end
			endcase
		end
	end

	assign readDone = (state_q == nvac_pkg::NVAC_READING)
		&& (readCount_q == RCW'(READ_CYCLES - 1));

	// programming time is set by the slow asynchronous timer
	nvac_write_timer #(
		.TICKS(WRITE_TICKS)
	) writeTimer (
		.mclk(mclk),
		.rst_n(rst_n),
		.start(startProgram),
		.tickPin(timerTick),
		.done(writeDone)
	);

	// array storage; no reset, contents survive like the real cells
	always_ff @(posedge mclk) begin
		if (writeDone) begin
			mem[cycleAddr_q] <= cycleData_q;
		end
	end

	// request flag: set at end of programming, cleared on service;
	// a set in the same cycle as the acknowledge wins
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqFlag_q <= 1'b0;
		end else if (writeDone) begin
			irqFlag_q <= 1'b1;
		end else if (irqAck) begin
			irqFlag_q <= 1'b0;
		end
	end

	// vector request needs both enables and a free stack entry
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			irqReq_q <= 1'b0;
		end else begin
			irqReq_q <= (irqFlag_q || writeDone) && !(irqAck && !writeDone)
				&& nvIrqEnable && globalIrqEnable && !stackFull;
		end
	end

	assign sfrRdata = rdata_q;
	assign nvIrqFlag = irqFlag_q;
	assign irqReq = irqReq_q;
	assign busy = busy_q;
endmodule : nvac_eeprom_ctrl
`default_nettype wire

//--- nvac_pkg.sv
// Overview of operation
// - program-enable must be set first; while clear, no programming cycle can start
// - setting program strobe starts a programming cycle; hardware clears it when done
// - program strobe set without program-enable already high is ignored
// - fetch-enable must be set first; while clear, no read cycle can start
// - setting fetch strobe starts a read cycle; hardware clears it when done
// - fetch strobe set while fetch-enable is low is ignored
// - upper four control bits are unimplemented and read as zero
// - data byte register holds the read byte until next read or software write
// - programming time comes from a timer asynchronous to the system clock
// - power-on clears program-enable so nothing is programmed until enabled
// - programming end sets the interrupt flag; vector only if enabled and stack free
// - servicing the interrupt clears the interrupt flag automatically
// - bank select resets to zero; control register lives only in bank 1
// - array holds 512 or 1024 bytes; upper address bits sit in high register
package nvac_pkg;
	// special function register offsets on the cpu side
	localparam logic [7:0] NVAC_INDIRECT_PORT_OFS = 8'h02;
	localparam logic [7:0] NVAC_POINTER_OFS = 8'h03;
	localparam logic [7:0] NVAC_BANK_SELECT_OFS = 8'h04;
	localparam logic [7:0] NVAC_ADDR_LOW_OFS = 8'h20;
	localparam logic [7:0] NVAC_ADDR_HIGH_OFS = 8'h21;
	localparam logic [7:0] NVAC_DATA_BYTE_OFS = 8'h22;
	localparam logic [7:0] NVAC_CONTROL_OFS = 8'h40;
	localparam logic [7:0] NVAC_CONTROL_BANK = 8'h01;
	localparam logic [7:0] NVAC_DATA_BANK = 8'h00;
	// control register fields
	localparam int NVAC_FETCH_BIT = 0;
	localparam int NVAC_FETCH_EN_BIT = 1;
	localparam int NVAC_PROG_BIT = 2;
	localparam int NVAC_PROG_EN_BIT = 3;
	// values after reset
	localparam logic [7:0] NVAC_BYTE_RESET = 8'h00;
	localparam logic [3:0] NVAC_CONTROL_RESET = 4'h0;
	// array depth and cycle counts
	localparam int NVAC_DEPTH = 512;
	localparam int NVAC_READ_CYCLES = 4;
	localparam int NVAC_WRITE_TICKS = 8;

	typedef struct packed {
		logic [7:0] addr; // register offset
		logic wr; // write this cycle
		logic rd; // read this cycle
		logic [7:0] wdata; // write data
	} nvac_sfr_req_t;

	typedef enum logic [1:0] {
		NVAC_IDLE,
		NVAC_READING,
		NVAC_WRITING
	} nvac_state_t;
endpackage : nvac_pkg

//--- nvac_write_timer.sv
`timescale 1ns/1ns
`default_nettype none
module nvac_write_timer #(
	parameter int TICKS = nvac_pkg::NVAC_WRITE_TICKS
) (
	input wire logic mclk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire logic start, // begin timing a programming cycle
	input wire logic tickPin, // free-running slow timer clock, async
	output logic done // one-cycle pulse at end of timing
);
	localparam int CW = $clog2(TICKS + 1);
	logic tickSync1_q;
	logic tickSync2_q;
	logic tickPrev_q;
	logic running_q;
	logic [CW-1:0] count_q;
	logic tickEdge;

	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tickSync1_q <= 1'b0;
			tickSync2_q <= 1'b0;
			tickPrev_q <= 1'b0;
		end else begin
			tickSync1_q <= tickPin;
			tickSync2_q <= tickSync1_q;
			tickPrev_q <= tickSync2_q;
		end
	end

	assign tickEdge = tickSync2_q & ~tickPrev_q;

	// cycle length depends on the slow timer, not on mclk
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			running_q <= 1'b0;
			count_q <= '0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				running_q <= 1'b1;
				count_q <= '0;
			end else if (running_q && tickEdge) begin
				if (count_q == CW'(TICKS - 1)) begin
					running_q <= 1'b0;
					done <= 1'b1;
				end else begin
					count_q <= count_q + 1'b1;
				end
			end
		end
	end
endmodule : nvac_write_timer
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	nvac_pkg::nvac_sfr_req_t sfrReq = '0;
	logic nvIrqEnable = 1'b0;
	logic globalIrqEnable = 1'b0;
	logic stackFull = 1'b0;
	logic [3:0] ackDelay = 4'h0;
	logic [7:0] sfrRdata;
	logic timerTick;
	logic irqAck;
	logic nvIrqFlag;
	logic irqReq;
	logic busy;
	logic [31:0] seed = 32'h0000_0046;
	logic [7:0] mem [0:511];
	logic [7:0] rd;
	logic [8:0] a;
	logic [7:0] d;
	logic [7:0] tv [5] = '{8'h04, 8'h01, 8'hF2, 8'hF8, 8'h00};
	int error_cnt = 0;
	int total_checks = 0;
	always #5 mclk = ~mclk;
	// short write time keeps the run brief
	nvac_eeprom_ctrl #(.WRITE_TICKS(2)) dut (.mclk(mclk), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
		.timerTick(timerTick), .nvIrqEnable(nvIrqEnable), .globalIrqEnable(globalIrqEnable), .stackFull(stackFull),
		.irqAck(irqAck), .nvIrqFlag(nvIrqFlag), .irqReq(irqReq), .busy(busy));
	nvac_cpu_model cpu (.mclk(mclk), .rst_n(rst_n), .irqReq(irqReq), .ackDelay(ackDelay), .timerTick(timerTick),
		.irqAck(irqAck));
	function automatic logic [31:0] xorshift(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction : xorshift
	// control value once no cycle runs: enables kept, strobes clear, top nibble zero
	function automatic logic [7:0] idleCtrl(input logic [7:0] v);
		return {4'h0, v[3], 1'b0, v[1], 1'b0};
	endfunction : idleCtrl
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk
	// one access per call, held across one edge; the next call replaces it
	task automatic acc(input logic w, input logic [7:0] ad, input logic [7:0] v);
		sfrReq = '{addr: ad, wr: w, rd: !w, wdata: v};
		@(posedge mclk);
		#1;
	endtask : acc
	// one quiet cycle with no access at all
	task automatic idle;
		sfrReq = '0;
		@(posedge mclk);
		#1;
	endtask : idle
	task automatic rdb(input logic [7:0] ad, output logic [7:0] v);
		acc(1'b0, ad, 8'h00);
		sfrReq = '0;
		@(posedge mclk);
		#1;
		v = sfrRdata;
	endtask : rdb
	// bounded wait on busy (sel 0) or the flag (sel 1); a timeout shows up as a mismatch
	task automatic waitFor(input logic sel, input logic lvl, input string msg);
		logic cur;
		cur = sel ? nvIrqFlag : busy;
		for (int n = 0; n < 400 && cur !== lvl; n++) begin
			@(posedge mclk);
			#1;
			cur = sel ? nvIrqFlag : busy;
		end
		chk({7'h0, cur}, {7'h0, lvl}, msg);
	endtask : waitFor
	// stage address and data in bank 0, then open the control register
	task automatic stage(input logic [8:0] ad, input logic [7:0] v);
		acc(1'b1, 8'h04, 8'h00);
		acc(1'b1, 8'h20, ad[7:0]);
		acc(1'b1, 8'h21, {7'h0, ad[8]});
		acc(1'b1, 8'h22, v);
		acc(1'b1, 8'h03, 8'h40);
		acc(1'b1, 8'h04, 8'h01);
	endtask : stage
	initial begin
		#200000;
		error_cnt++;
		$display("BAD %0t watchdog", $time);
		complete_run();
	end
	initial begin
		repeat (20) @(posedge mclk);
		#1 rst_n = 1'b1;
		rdb(8'h04, rd); chk(rd, 8'h00, "bank");
		rdb(8'h22, rd); chk(rd, 8'h00, "data");
		acc(1'b1, 8'h21, 8'hFF); rdb(8'h21, rd); chk(rd, 8'h01, "addr high");
		rdb(8'h30, rd); chk(rd, 8'h00, "unmapped");
		acc(1'b1, 8'h03, 8'h40); acc(1'b1, 8'h04, 8'h01);
		rdb(8'h02, rd); chk(rd, 8'h00, "ctrl reset");
		// lone strobes and unimplemented bits
		foreach (tv[i]) begin
			acc(1'b1, 8'h02, tv[i]); idle; chk({7'h0, busy}, 8'h00, "no start");
			rdb(8'h02, rd); chk(rd, idleCtrl(tv[i]), "ctrl");
		end
		nvIrqEnable = 1'b1;
		for (int k = 0; k < 4; k++) begin
			seed = xorshift(seed);
			a = (k == 0) ? 9'h1FF : seed[8:0];
			d = seed[23:16];
			stackFull = seed[24];
			globalIrqEnable = 1'b0;
			stage(a, d);
			acc(1'b1, 8'h02, 8'h08); acc(1'b1, 8'h02, 8'h0C); idle;
			globalIrqEnable = 1'b1;
			chk({7'h0, busy}, 8'h01, "prog busy");
			rdb(8'h02, rd); chk(rd, 8'h0C, "strobe held");
			waitFor(1'b0, 1'b0, "prog end");
			chk({7'h0, nvIrqFlag}, 8'h01, "flag");
			rdb(8'h02, rd); chk(rd, idleCtrl(8'h0C), "strobe clear");
			chk({7'h0, irqReq}, {7'h0, !stackFull}, "vector");
			mem[a] = d;
			stackFull = 1'b0;
			ackDelay = 4'h3;
			waitFor(1'b1, 1'b0, "service");
			ackDelay = 4'h0;
			// read back through stale data; a second strobe during the read is dropped
			stage(a, ~d);
			acc(1'b1, 8'h02, 8'h0A); acc(1'b1, 8'h02, 8'h0B); idle;
			chk({7'h0, busy}, 8'h01, "read busy");
			acc(1'b1, 8'h02, 8'h0E); idle;
			waitFor(1'b0, 1'b0, "read end");
			rdb(8'h02, rd); chk(rd, idleCtrl(8'h0B), "read strobe");
			chk({7'h0, nvIrqFlag}, 8'h00, "no prog");
			acc(1'b1, 8'h02, 8'h00); acc(1'b1, 8'h04, 8'h00);
			rdb(8'h22, rd); chk(rd, mem[a], "read data");
			rdb(8'h22, rd); chk(rd, mem[a], "data held");
		end
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
